// ===== logic/mzcp_consts.vh
/*
 * Constants of the mains zero-crossing predictor: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef MZCP_CONSTS_VH
`define MZCP_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MZCP_ADDR_W          4
`define MZCP_DATA_W          16
`define MZCP_OFS_CONFIG      4'h0
`define MZCP_OFS_FILTER      4'h4
`define MZCP_OFS_STATUS      4'h8
`define MZCP_OFS_PERIOD      4'hC

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MZCP_CFG_MUX_BIT     0
`define MZCP_CFG_ASC_BIT     1
`define MZCP_CFG_INV_BIT     2
`define MZCP_CFG_REP_BIT     3
`define MZCP_FLT_BP_BIT      0
`define MZCP_STS_LOCK_BIT    0
`define MZCP_CFG_RESET       4'h0
`define MZCP_FLT_RESET       1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MZCP_CLK_NS          40
`define MZCP_TICK_NS         1000
`define MZCP_TICK_DIV        (`MZCP_TICK_NS / `MZCP_CLK_NS)
`define MZCP_HALF_MIN_US     16'h1D97
`define MZCP_HALF_MAX_US     16'h2B67
`define MZCP_FULL_MIN_US     16'h3B2F
`define MZCP_FULL_MAX_US     16'h56CE
`define MZCP_FILT_LEN        4
`define MZCP_HOLD_US         200
`define MZCP_LOCK_CNT        4

`endif

// ===== logic/mzcp_input_cond.v
/*
 * Input conditioner of the zero-crossing predictor: glitch filter,
 * polarity inversion and edge hold-off ahead of the tracking loop.
 * Assumes a one-cycle tick enable of 1 us and a synchronous input.
 */
`include "mzcp_consts.vh"

module mzcp_input_cond #(
  parameter FILT_LEN = `MZCP_FILT_LEN,
  parameter HOLD_US  = `MZCP_HOLD_US
) (
  // Clock and reset
  input  wire clock,
  input  wire rst,
  input  wire tick,
  // Control
  input  wire invert_sel,
  input  wire repeat_sel,
  input  wire filter_bypass,
  // Pulse path
  input  wire mains_pulse_in,
  output reg  cond_ff
);

  // ----------------------------------------------------------------
  // Filter and hold-off
  // ----------------------------------------------------------------
  reg [FILT_LEN-1:0] hist_ff;
  reg [15:0]         hold_ff;
  wire               pol = mains_pulse_in ^ invert_sel;
  wire               all_hi = &hist_ff;
  wire               all_lo = ~|hist_ff;
  reg                nxt_cond;

  always @* begin
    nxt_cond = cond_ff;
    if (filter_bypass) begin
      nxt_cond = pol;
    end else if (all_hi) begin
      nxt_cond = 1'b1;
    end else if (all_lo) begin
      nxt_cond = 1'b0;
    end
    if (repeat_sel && hold_ff != 16'h0000) begin
      nxt_cond = cond_ff;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      hist_ff <= {FILT_LEN{1'b0}};
      hold_ff <= 16'h0000;
      cond_ff <= 1'b0;
    end else if (tick) begin
      hist_ff <= {hist_ff[FILT_LEN-2:0], pol}; // RULE4 RULE5
      cond_ff <= nxt_cond; // RULE4
      if (nxt_cond != cond_ff) begin
        hold_ff <= HOLD_US[15:0];
      end else if (hold_ff != 16'h0000) begin
        hold_ff <= hold_ff - 16'h0001;
      end
    end
  end

endmodule

// ===== logic/mzcp_predictor.v
/*
 * Mains zero-crossing predictor: register port, input conditioner and
 * a phase-locked tracking loop that forecasts crossings.
 * Assumes a 25 MHz clock, synchronous inputs, and a master that keeps
 * the strobes one cycle long and never both at once.
 */
// Summary of operation
// [RULE1] Forecast crossings from past ones via conditioner and tracking loop; flag each.
// [RULE2] Lock to 50 or 60 Hz mains within ten percent either way.
// [RULE3] Crossing instant is the midpoint of each conditioned high pulse.
// [RULE4] Conditioner applies invert and repeat so midpoints match true crossings.
// [RULE5] Input duty above 60 or below 40 percent; polarity selectable.
// [RULE6] Mux picks both-direction or single-direction; rise/fall bit picks edge.
// [RULE7] Full-wave input: software sets mux 0, asc 0, inv 1, rep 0, bypass 0.
// [RULE8] Single-direction: mux 1, asc per edge, inv 1, rep 1, bypass 0.
// [RULE9] The mains pulse pin is a plain digital input into the detector.
// [RULE10] Flag is one clock wide per predicted crossing; reset clears all.
`include "mzcp_consts.vh"

module mzcp_predictor #(
  parameter FILT_LEN = `MZCP_FILT_LEN,
  parameter HOLD_US  = `MZCP_HOLD_US,
  parameter LOCK_CNT = `MZCP_LOCK_CNT,
  parameter TICK_DIV = `MZCP_TICK_DIV
) (
  // Clock and reset
  input  wire                    clock,
  input  wire                    rst,
  // Register port
  input  wire [`MZCP_ADDR_W-1:0] reg_addr,
  input  wire [`MZCP_DATA_W-1:0] reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`MZCP_DATA_W-1:0] reg_rdata_ff,
  // Mains side
  input  wire                    mains_pulse_in,
  output reg                     zc_flag_ff,
  output reg                     locked_ff
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [3:0]  crossing_config_ff;
  reg         filter_bypass_ff;
  reg  [15:0] per_ff;
  wire        direction_mux_sel = crossing_config_ff[`MZCP_CFG_MUX_BIT];
  wire        rise_fall_sel     = crossing_config_ff[`MZCP_CFG_ASC_BIT];

  function [`MZCP_DATA_W-1:0] rd_mux;
    input [`MZCP_ADDR_W-1:0] a;
    input [3:0]              cfg;
    input                    bp;
    input                    lk;
    input [15:0]             per;
    begin
      case (a)
        `MZCP_OFS_CONFIG: rd_mux = {12'h000, cfg};
        `MZCP_OFS_FILTER: rd_mux = {15'h0000, bp};
        `MZCP_OFS_STATUS: rd_mux = {15'h0000, lk};
        `MZCP_OFS_PERIOD: rd_mux = per;
        default:          rd_mux = 16'h0000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  function wr_hit;
    input                    wr;
    input [`MZCP_ADDR_W-1:0] a;
    input [`MZCP_ADDR_W-1:0] ofs;
    begin
      wr_hit = wr && (a == ofs);
    end
  endfunction

  always @(posedge clock) begin
    if (rst) begin
      crossing_config_ff <= `MZCP_CFG_RESET;
      filter_bypass_ff   <= `MZCP_FLT_RESET;
      reg_rdata_ff       <= 16'h0000;
    end else begin
      if (wr_hit(reg_wr, reg_addr, `MZCP_OFS_CONFIG)) begin
        crossing_config_ff <= reg_wdata[3:0]; // RULE6
      end
      if (wr_hit(reg_wr, reg_addr, `MZCP_OFS_FILTER)) begin
        filter_bypass_ff <= reg_wdata[`MZCP_FLT_BP_BIT];
      end
      if (reg_rd) begin
        reg_rdata_ff <= rd_mux(reg_addr, crossing_config_ff, filter_bypass_ff,
                               locked_ff, per_ff);
      end else begin
        reg_rdata_ff <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Microsecond tick
  // ----------------------------------------------------------------
  reg  [7:0] div_ff;
  reg        tick_ff;
  localparam integer TICK_M1   = TICK_DIV - 1;
  localparam [7:0]   TICK_LAST = TICK_M1[7:0];

  always @(posedge clock) begin
    if (rst) begin
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == TICK_LAST);
      div_ff  <= (div_ff == TICK_LAST) ? 8'h00 : div_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Input conditioner
  // ----------------------------------------------------------------
  wire cond;

  mzcp_input_cond #(
    .FILT_LEN (FILT_LEN),
    .HOLD_US  (HOLD_US)
  ) i_mzcp_input_cond (
    .clock          (clock),
    .rst            (rst),
    .tick           (tick_ff),
    .invert_sel     (crossing_config_ff[`MZCP_CFG_INV_BIT]),
    .repeat_sel     (crossing_config_ff[`MZCP_CFG_REP_BIT]),
    .filter_bypass  (filter_bypass_ff),
    .mains_pulse_in (mains_pulse_in), // RULE9
    .cond_ff        (cond)
  );

  // ----------------------------------------------------------------
  // Tracking loop
  // ----------------------------------------------------------------
  localparam [15:0] HALF_MIN = `MZCP_HALF_MIN_US;
  localparam [15:0] HALF_MAX = `MZCP_HALF_MAX_US;
  localparam [15:0] FULL_MIN = `MZCP_FULL_MIN_US;
  localparam [15:0] FULL_MAX = `MZCP_FULL_MAX_US;
  localparam [3:0]  LOCK_N   = LOCK_CNT[3:0];

  reg         prev_ff;
  reg  [15:0] wid_ff;
  reg  [15:0] ph_ff;
  reg  [15:0] fc_ff;
  reg  [3:0]  good_ff;
  reg         seen_ff;

  wire [15:0] lim_min  = direction_mux_sel ? FULL_MIN : HALF_MIN;
  wire [15:0] lim_max  = direction_mux_sel ? FULL_MAX : HALF_MAX;
  wire        fall     = prev_ff & ~cond;
  wire        rise     = ~prev_ff & cond;
  wire [15:0] half_w   = {1'b0, wid_ff[15:1]};
  wire [15:0] meas     = ph_ff + 16'h0001 - half_w;
  wire        in_range = (meas >= lim_min) && (meas <= lim_max);
  wire [16:0] diff     = {1'b0, meas} - {1'b0, per_ff};
  wire [15:0] adj      = {diff[16], diff[16], diff[15:2]};
  wire [15:0] target   = (direction_mux_sel && rise_fall_sel) ?
                         {1'b0, per_ff[15:1]} : per_ff;
  wire        lost     = (ph_ff == 16'hFFFF);
  wire        late     = (fc_ff >= {1'b0, per_ff[15:1]}) && !rise_fall_sel;

  always @(posedge clock) begin
    if (rst) begin
      prev_ff    <= 1'b0;
      wid_ff     <= 16'h0000;
      ph_ff      <= 16'h0000;
      fc_ff      <= 16'h0000;
      per_ff     <= 16'h0000;
      good_ff    <= 4'h0;
      seen_ff    <= 1'b0;
      locked_ff  <= 1'b0;
      zc_flag_ff <= 1'b0; // RULE10
    end else begin
      zc_flag_ff <= 1'b0; // RULE10
      if (tick_ff) begin
        prev_ff <= cond;
        if (rise) begin
          wid_ff <= 16'h0001;
        end else if (cond && wid_ff != 16'hFFFF) begin
          wid_ff <= wid_ff + 16'h0001;
        end
        if (fall) begin
          ph_ff   <= half_w; // RULE3
          seen_ff <= 1'b1;
          if (seen_ff && in_range) begin // RULE2
            per_ff  <= locked_ff ? per_ff + adj : meas; // RULE1
            good_ff <= (good_ff == LOCK_N) ? good_ff : good_ff + 4'h1;
            if (good_ff >= LOCK_N - 4'h1) begin
              locked_ff <= 1'b1;
            end
            fc_ff <= half_w; // RULE3
            if (locked_ff && late) begin
              zc_flag_ff <= 1'b1; // RULE1
            end
          end else begin
            good_ff   <= 4'h0;
            locked_ff <= 1'b0;
          end
        end else begin
          if (!lost) begin
            ph_ff <= ph_ff + 16'h0001;
          end else begin
            good_ff   <= 4'h0;
            locked_ff <= 1'b0;
            seen_ff   <= 1'b0;
          end
          fc_ff <= (fc_ff >= per_ff) ? 16'h0001 : fc_ff + 16'h0001;
          // No forecast once the input is declared lost
          if (locked_ff && !lost && fc_ff == target) begin
            zc_flag_ff <= 1'b1; // RULE1 RULE6 RULE10
          end
        end
      end
    end
  end

endmodule

// ===== sim/mzcp_mains_model.sv
/* Model of the external mains sensing circuit.
   Assumes interval_us is the pulse spacing in ticks of TICK_DIV clocks. */
module mzcp_mains_model #(
  parameter int TICK_DIV = 25
) (
  // Clock and control
  input  logic        clock,
  input  logic        run,
  input  logic [15:0] interval_us,
  // Pulse pin
  output logic        mains_pulse_in
);
  logic [23:0] cnt_ff;
  always @(posedge clock) begin
    if (!run || cnt_ff >= interval_us * TICK_DIV - 1) begin
      cnt_ff <= 24'h000000;
    end else begin
      cnt_ff <= cnt_ff + 24'h000001;
    end
  end
  // Short low dip each interval, duty 80 percent; pulled down when idle
  assign mains_pulse_in = run && cnt_ff * 5 >= interval_us * TICK_DIV;
endmodule

// ===== sim/mzcp_monitor.sv
/* Checker of the zero-crossing predictor ports.
   Assumes a bind onto mzcp_predictor. */
module mzcp_monitor #(
  parameter int GAP_MIN = 25000
) (
  // Clock and reset
  input logic        clock,
  input logic        rst,
  // Register port
  input logic [3:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata_ff,
  // Mains side
  input logic        zc_flag_ff,
  input logic        locked_ff
);
  logic [15:0] gap_ff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Cycles since the last flag, saturating
  always @(posedge clock) gap_ff <= (rst || zc_flag_ff) ? 16'h0000 : gap_ff + {15'h0000, ~&gap_ff};
  flag_one_cyc_a: assert property (zc_flag_ff |=> !zc_flag_ff) else $error("flag wide");
  flag_locked_a: assert property (zc_flag_ff |-> locked_ff) else $error("flag unlocked");
  flag_gap_a: assert property (zc_flag_ff |-> gap_ff > GAP_MIN) else $error("flag gap");
  rst_clear_a: assert property (disable iff (1'b0) rst |=> !zc_flag_ff && !locked_ff
    && reg_rdata_ff == 16'h0000) else $error("reset");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000) else $error("idle");
  cfg_back_a: assert property (reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0
    |=> reg_rdata_ff == {12'h000, $past(reg_wdata[3:0], 2)}) else $error("config");
  flt_back_a: assert property (reg_wr && reg_addr == 4'h4 ##1 reg_rd && reg_addr == 4'h4
    |=> reg_rdata_ff == {15'h0000, $past(reg_wdata[0], 2)}) else $error("filter");
  unmap_rd_a: assert property (reg_rd && reg_addr[1:0] != 2'b00 |=> reg_rdata_ff == 16'h0000)
    else $error("unmapped");
  cover property ($rose(locked_ff));
  cover property (zc_flag_ff);
  cover property (reg_wr && reg_addr == 4'h0);
  cover property (reg_wr && reg_addr == 4'h0 && reg_wdata[0]);
endmodule

// ===== sim/tb_mains_zero_cross_predictor.sv
/* Self-checking bench of the zero-crossing predictor.
   Assumes the predictor, its checker and the mains model. */
module tb_mains_zero_cross_predictor;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata_ff;
  logic        mains_pulse_in;
  logic        zc_flag_ff;
  logic        locked_ff;
  logic        run = 1'b0;
  logic [15:0] interval_us = 16'h1F40;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n_flag = 0;
  int          cycles = 0;
  // One tick per clock and a short lock count keep the run short
  mzcp_predictor #(.TICK_DIV(1), .LOCK_CNT(2)) i_mzcp_predictor (.clock, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .mains_pulse_in, .zc_flag_ff, .locked_ff);
  mzcp_mains_model #(.TICK_DIV(1)) i_mzcp_mains_model (.clock, .run, .interval_us,
    .mains_pulse_in);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (zc_flag_ff === 1'b1) n_flag++;
    if (cycles == 95000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // One register cycle; a read waits one more edge and takes the answer standing before it
  task automatic access(input logic w, input logic [3:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    q = 16'h0000;
    if (!w) begin
      reg_rd <= 1'b0;
      @(posedge clock);
      q = reg_rdata_ff;
    end
  endtask
  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs;
    logic [15:0] q;
    logic [3:0]  a[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    logic [3:0]  m[3] = '{4'h4, 4'hD, 4'hF};
    foreach (a[i]) begin
      access(1'b0, a[i], 16'h0000, q);
      check("reset value", 16'h0000, q);
    end
    access(1'b1, 4'h0, 16'hFFFF, q);
    access(1'b0, 4'h0, 16'h0000, q);
    check("config", 16'h000F, q);
    access(1'b1, 4'h4, 16'hFFFF, q);
    access(1'b0, 4'h4, 16'h0000, q);
    check("filter", 16'h0001, q);
    access(1'b1, 4'h8, 16'hFFFF, q);
    access(1'b1, 4'h2, 16'h0000, q);
    access(1'b0, 4'h8, 16'h0000, q);
    check("status", 16'h0000, q);
    access(1'b0, 4'h0, 16'h0000, q);
    check("config kept", 16'h000F, q);
    foreach (m[i]) begin
      access(1'b1, 4'h0, {12'h000, m[i]}, q);
      access(1'b0, 4'h0, 16'h0000, q);
      check("mode", {12'h000, m[i]}, q);
    end
    idle();
  endtask
  task automatic test_lock;
    logic [15:0] q;
    int          k;
    access(1'b1, 4'h0, 16'h0004, q);
    access(1'b1, 4'h4, 16'h0000, q);
    idle();
    run <= 1'b1;
    for (k = 0; locked_ff !== 1'b1 && k < 30000; k++) @(posedge clock);
    check("locked", 16'h0001, {15'h0000, locked_ff});
    for (k = 0; zc_flag_ff !== 1'b1 && k < 10000; k++) @(posedge clock);
    @(posedge clock);
    k = n_flag;
    repeat (20000) @(posedge clock);
    check("flags", 16'h0002, 16'(n_flag - k));
    access(1'b0, 4'hC, 16'h0000, q);
    check("period", 16'h1F40, q);
    idle();
  endtask
  task automatic test_unlock;
    int k;
    interval_us <= 16'h1388;
    for (k = 0; locked_ff !== 1'b0 && k < 30000; k++) @(posedge clock);
    check("unlock", 16'h0000, {15'h0000, locked_ff});
  endtask
  // Single-direction set-up refuses an interval that locks in both-direction mode
  task automatic test_single;
    logic [15:0] q;
    int          k;
    access(1'b1, 4'h0, 16'h000D, q);
    idle();
    interval_us <= 16'h1F40;
    k = n_flag;
    repeat (25000) @(posedge clock);
    check("single lock", 16'h0000, {15'h0000, locked_ff});
    check("single flags", 16'h0000, 16'(n_flag - k));
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    test_regs();
    test_lock();
    test_unlock();
    test_single();
    print_verdict();
  end
endmodule
bind mzcp_predictor mzcp_monitor #(.GAP_MIN(1000)) i_mzcp_monitor (.clock, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .zc_flag_ff, .locked_ff);
